// ==== bench/loader_chk_assertions.sv ====
// port assertions for the motion parameter loader
`timescale 1ns/10ps
module loader_chk #(
    parameter NUM_AXES = 4,
    parameter [31:0] VEL_MAX = 32'h0fff_ffff,
    parameter [31:0] ACC_MAX = 32'h00ff_ffff
) (
    // clock, reset and register port
    input wire mclk,
    input wire arst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    // axis outputs
    input wire [NUM_AXES*32-1:0] vel_out,
    input wire [NUM_AXES*32-1:0] acc_out,
    input wire [NUM_AXES*16-1:0] steps_out,
    input wire [NUM_AXES*16-1:0] lines_out,
    input wire [NUM_AXES*32-1:0] dest_out,
    input wire [NUM_AXES-1:0] start_pulse,
    input wire cmd_err
);
    // shadow of the servo and closed-loop bits, needed to know when a load must be refused
    reg [1:0] loop_cfg;
    wire sl_wr = wr && addr == 8'h10;
    wire go_wr = wr && addr == 8'h18;
    genvar k;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            loop_cfg <= 2'h0;
        else if (wr && addr == 8'h00)
            loop_cfg <= wdata[1:0];
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    chk_open_flags: assert property (sl_wr && loop_cfg == 2'h0 |=> cmd_err)
        else $error("refused load did not flag");
    chk_open_keeps: assert property (sl_wr && loop_cfg == 2'h0 |=> $stable(steps_out)
        && $stable(lines_out)) else $error("refused load changed steps or lines");
    chk_clamp_quiet: assert property (sl_wr && loop_cfg != 2'h0 && !cmd_err |=> !cmd_err)
        else $error("accepted load raised error");
    chk_start_mask: assert property (go_wr |=> start_pulse == $past(wdata[NUM_AXES-1:0]))
        else $error("start pulse does not follow mask");
    chk_start_only: assert property (!go_wr |=> start_pulse == '0)
        else $error("start pulse without start write");
    chk_dest_cause: assert property ($changed(dest_out) |-> $past(go_wr))
        else $error("destination changed without start");
    chk_vel_cause: assert property ($changed(vel_out) |-> $past(wr && addr == 8'h08))
        else $error("velocity changed without load");
    chk_acc_cause: assert property ($changed(acc_out) |-> $past(wr && addr == 8'h0c))
        else $error("acceleration changed without load");
    for (k = 0; k < NUM_AXES; k = k + 1) begin : ax
        chk_steps_range: assert property (steps_out[k*16+:16] inside {[16'h1:16'h7fff]})
            else $error("steps out of range");
        chk_lines_range: assert property (lines_out[k*16+:16] inside {[16'h1:16'h3fff]})
            else $error("lines out of range");
        chk_vel_limit: assert property (vel_out[k*32+:32] <= VEL_MAX)
            else $error("velocity above limit");
        chk_acc_limit: assert property (acc_out[k*32+:32] <= ACC_MAX)
            else $error("acceleration above limit");
    end
endmodule

bind axis_motion_param_loader loader_chk #(.NUM_AXES(NUM_AXES), .VEL_MAX(VEL_MAX),
    .ACC_MAX(ACC_MAX)) loader_chk_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .vel_out(vel_out), .acc_out(acc_out), .steps_out(steps_out),
    .lines_out(lines_out), .dest_out(dest_out), .start_pulse(start_pulse), .cmd_err(cmd_err));

// ==== bench/motion_core_model.sv ====
// trajectory core stand-in: each started axis stops at its destination
`timescale 1ns/10ps
module motion_core_model #(
    parameter NUM_AXES = 4
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // from the loader
    input wire [NUM_AXES-1:0] start_pulse,
    input wire [NUM_AXES*32-1:0] dest_out,
    // back to the loader
    output reg [NUM_AXES*32-1:0] stop_pos
);
    integer k;
    reg [7:0] run [0:NUM_AXES-1];
    // odd axes finish promptly, even axes take a long move
    always @(posedge mclk or negedge arst_n) begin
        for (k = 0; k < NUM_AXES; k = k + 1) begin
            if (!arst_n) begin
                run[k] <= 8'h0;
                stop_pos[k*32+:32] <= 32'h0;
            end else if (start_pulse[k]) begin
                run[k] <= k[0] ? 8'h2 : 8'h28;
            end else if (run[k] == 8'h1) begin
                run[k] <= 8'h0;
                stop_pos[k*32+:32] <= dest_out[k*32+:32];
            end else if (run[k] != 8'h0) begin
                run[k] <= run[k] - 8'h1;
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the motion parameter loader
`timescale 1ns/10ps
`include "axis_param_defines.vh"
module testbench;
    localparam [31:0] VMAX = 32'h0001_0000;
    localparam [31:0] AMAX = 32'h0010_0000;
    typedef struct {logic [31:0] v; string n;} note_t;
    reg mclk, arst_n, wr, rd, rd_q;
    reg [7:0] addr;
    reg [31:0] wdata, seed, d, t1, t2;
    reg [95:0] v;
    wire [31:0] rdata;
    wire [127:0] stop_pos, vel_out, acc_out, dest_out;
    wire [63:0] steps_out, lines_out;
    wire [3:0] start_pulse;
    wire cmd_err;
    integer errors, n_checks, i, m;
    note_t notes[$];
    note_t nt;
    axis_motion_param_loader #(.VEL_MAX(VMAX), .ACC_MAX(AMAX)) axis_motion_param_loader_inst (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .stop_pos(stop_pos), .vel_out(vel_out), .acc_out(acc_out),
        .steps_out(steps_out), .lines_out(lines_out), .dest_out(dest_out),
        .start_pulse(start_pulse), .cmd_err(cmd_err));
    motion_core_model motion_core_model_inst (.mclk(mclk), .arst_n(arst_n),
        .start_pulse(start_pulse), .dest_out(dest_out), .stop_pos(stop_pos));
    function [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xorshift = seed;
    endfunction
    function [15:0] clamp(input [15:0] x, input [15:0] mx);
        clamp = x == 16'h0 ? 16'h1 : (x > mx ? mx : x);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task bus(input w, input r, input [7:0] a, input [31:0] x);
        @(posedge mclk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= x;
    endtask
    task wrt(input [7:0] a, input [31:0] x);
        bus(1'b1, 1'b0, a, x);
    endtask
    task rdc(input [7:0] a, input [31:0] e, input string n);
        notes.push_back('{e, n});
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task idle(input integer n);
        bus(1'b0, 1'b0, addr, wdata);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wait_stop(input integer k, input [31:0] x);
        for (i = 0; i < 100 && stop_pos[k*32+:32] !== x; i = i + 1)
            @(posedge mclk);
        if (i == 100) begin
            errors = errors + 1;
            wrap_up();
        end
    endtask
    // --------------------------------
    // read data checker
    // --------------------------------
    always @(posedge mclk) begin
        rd_q <= rd;
        if (rd_q) begin
            nt = notes.pop_front();
            chk(nt.n, nt.v, rdata);
        end
    end
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #400000;
        errors = errors + 1;
        wrap_up();
    end
    initial begin
        {arst_n, wr, rd, addr, wdata} = 0;
        seed = 32'hb965fdfe;
        errors = 0;
        n_checks = 0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        for (m = 0; m < 4; m = m + 1) begin
            chk("steps", 32'd200, {16'h0, steps_out[m*16+:16]});
            chk("lines", 32'd200, {16'h0, lines_out[m*16+:16]});
        end
        rdc(8'h40, 32'h0, "unmapped");
        rdc(`REG_START, 32'h0, "start");
        wrt(`REG_STEPS_LINES, 32'h0032_0064);
        rdc(`REG_STATUS, 32'h1, "status");
        rdc(`REG_STEPS_LINES, 32'h00c8_00c8, "steps_lines");
        wrt(`REG_STATUS, 32'h1);
        rdc(`REG_STATUS, 32'h0, "status");
        idle(2);
        $display("test open loop done");
        wrt(`REG_CFG, 32'h2);
        wrt(`REG_AXIS_SEL, 32'h1);
        for (m = 0; m < 4; m = m + 1) begin
            d = m == 0 ? 32'h0 : (m == 1 ? 32'hffff_ffff : xorshift());
            wrt(`REG_STEPS_LINES, d);
            rdc(`REG_STEPS_LINES, {clamp(d[31:16], 16'h3fff), clamp(d[15:0], 16'h7fff)}, "sl");
        end
        rdc(`REG_STATUS, 32'h0, "status");
        idle(2);
        chk("lines axis1", {16'h0, clamp(d[31:16], 16'h3fff)}, {16'h0, lines_out[31:16]});
        chk("steps axis0", 32'd200, {16'h0, steps_out[15:0]});
        $display("test steps lines done");
        wrt(`REG_STEPS_LINES, {16'd50, 16'd2000});
        for (m = 0; m < 8; m = m + 1) begin
            v = m[0] ? 96'd60 : 96'd1000;
            wrt(`REG_CFG, m[2] ? 32'h3 : 32'h2);
            case (m[2:1])
                2'd0: v = v * 2000 * 96'h0444_4445 >> 32;
                2'd1: v = v * 2000;
                2'd2: v = v * 50 * ((96'd1364 << 48) / 96'd60000000) >> 32;
                default: v = v * 50 * ((96'd465124 << 48) / 96'd1000000000000) >> 32;
            endcase
            wrt(m[1] ? `REG_ACC : `REG_VEL, m[0] ? 32'd60 : 32'd1000);
            d = m[1] ? AMAX : VMAX;
            rdc(m[1] ? `REG_ACC : `REG_VEL, v > d ? d : v[31:0], "conv");
        end
        idle(2);
        chk("vel axis0", 32'h0, vel_out[31:0]);
        $display("test conversion done");
        wrt(`REG_CFG, 32'h2);
        wrt(`REG_AXIS_SEL, 32'h2);
        t1 = xorshift();
        t2 = xorshift();
        wrt(`REG_TARGET, t1);
        wrt(`REG_TARGET, t2);
        rdc(`REG_STATUS, 32'h400, "pending");
        rdc(`REG_TARGET, t2, "target");
        idle(2);
        chk("dest early", 32'h0, dest_out[95:64]);
        wrt(`REG_START, 32'h4);
        idle(1);
        rdc(`REG_DEST, t2, "dest abs");
        rdc(`REG_STATUS, 32'h0, "pending");
        idle(1);
        wait_stop(2, t2);
        wrt(`REG_CFG, 32'h6);
        wrt(`REG_TARGET, t1);
        wrt(`REG_CFG, 32'h2);
        wrt(`REG_START, 32'h4);
        idle(1);
        rdc(`REG_DEST, t2 + t1, "dest rel");
        idle(4);
        $display("test target done");
        wrap_up();
    end
endmodule

// ==== src/axis_motion_param_loader.v ====
// per-axis velocity, acceleration, steps/lines and target position loader
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "axis_param_defines.vh"

module axis_motion_param_loader #(
    parameter NUM_AXES = 4,
    parameter AXW = 2,
    parameter SAMPLE_US = 341,
    parameter [31:0] VEL_MAX = 32'h0fff_ffff,
    parameter [31:0] ACC_MAX = 32'h00ff_ffff,
    parameter [2:0] CFG_RESET = 3'h1
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // last stopped position per axis, from the trajectory core
    input wire [NUM_AXES*32-1:0] stop_pos,
    // per-axis parameters to the trajectory core
    output reg [NUM_AXES*32-1:0] vel_out,
    output reg [NUM_AXES*32-1:0] acc_out,
    output reg [NUM_AXES*16-1:0] steps_out,
    output reg [NUM_AXES*16-1:0] lines_out,
    output reg [NUM_AXES*32-1:0] dest_out,
    output reg [NUM_AXES-1:0] start_pulse,
    // command status
    output reg cmd_err
);

// ----------------------------------------------------------------
// register map and limits
// ----------------------------------------------------------------
// cfg: bit 0 servo, bit 1 closed loop, bit 2 relative mode
// cfg resets to an open-loop stepper in absolute mode
// axis_sel: axis that every access below except start and status goes to
// vel: written as whole rpm, read back as the converted rate
// acc: written as whole rpsps, read back as the converted rate
// steps_lines: lines in the upper half, steps in the lower half
// target: pending value of the selected axis
// start: one bit per axis, reads as zero
// status: bit 0 sticky command error, write one to clear it
// status: one pending flag per axis from bit 8 up
// dest: destination taken at the last start of the selected axis
// every other offset is ignored on write and reads as zero
// read data stand for one cycle after the read strobe only
// limitation: rates are converted once, when written, from the
// steps or lines the axis holds at that moment; a later
// steps_lines load does not rescale a rate already stored
// trade-off: fractional rpm is left to the host, which keeps
// every multiplier at 64 bits and the conversion in one clock
// servo rates come out as 16.16 counts per sample period
// stepper velocity is whole steps per second, truncated
// a start with nothing pending repeats the last pending value
// relative moves are resolved at start, not at load, so the base
// is the position at which the axis last stopped
// the position mode is latched with each target, so changing it
// afterwards does not reinterpret a value already loaded
// board kind and loop mode come from cfg and apply to all axes
// a refused steps_lines load leaves both fields untouched
// a target load and a start in one cycle keep the new target
// pending, while the start uses the value held before it
// no write ever stalls the bus; all decisions take one edge

// ----------------------------------------------------------------
// conversion constants
// ----------------------------------------------------------------
// servo scale yields 16.16 counts per sample period
localparam [63:0] SERVO_VEL_K =
    (`COUNTS_PER_LINE * SAMPLE_US * (64'h1 << `FRAC_SHIFT)) / `US_PER_MIN;
// the acceleration scale overflows 64 bits before the divide,
// so it is worked out at 128 bits and cut afterwards
localparam [127:0] SERVO_ACC_WIDE =
    ({64'h0, `COUNTS_PER_LINE} * SAMPLE_US * SAMPLE_US * (128'h1 << `FRAC_SHIFT))
    / {64'h0, `US2_PER_S2};
localparam [63:0] SERVO_ACC_K = SERVO_ACC_WIDE[63:0];

// ----------------------------------------------------------------
// configuration and selection
// ----------------------------------------------------------------
reg [2:0] cfg;
reg [AXW-1:0] axis_sel;
reg [NUM_AXES*32-1:0] pend_target;
reg [NUM_AXES-1:0] pend_valid;
reg [NUM_AXES-1:0] pend_rel;

wire servo = cfg[`CFG_SERVO];
wire closed = cfg[`CFG_CLOSED];
wire relative = cfg[`CFG_RELATIVE];
wire open_stepper = !servo && !closed;

// addresses decode in full, so aliases of a register never hit it
// and a stray write elsewhere changes nothing
wire wr_cfg = wr && (addr == `REG_CFG);
wire wr_sel = wr && (addr == `REG_AXIS_SEL);
wire wr_vel = wr && (addr == `REG_VEL);
wire wr_acc = wr && (addr == `REG_ACC);
wire wr_sl = wr && (addr == `REG_STEPS_LINES);
wire wr_tgt = wr && (addr == `REG_TARGET);
wire wr_start = wr && (addr == `REG_START);
wire wr_sts = wr && (addr == `REG_STATUS);

wire [15:0] sel_steps = steps_out[axis_sel*16 +: 16];
wire [15:0] sel_lines = lines_out[axis_sel*16 +: 16];

// ----------------------------------------------------------------
// velocity conversion
// ----------------------------------------------------------------
// rpm and rpsps are whole numbers in the low 16 bits
// servo scales by encoder lines, stepper by steps per revolution
wire [63:0] rate_word = {48'h0, wdata[15:0]};
wire [63:0] per_rev = servo ? {48'h0, sel_lines} : {48'h0, sel_steps};
reg [63:0] vel_base;
reg [63:0] vel_wide;
reg [31:0] next_vel;

always @* begin
    vel_base = rate_word * per_rev;
    if (servo) begin
        vel_wide = (vel_base * SERVO_VEL_K) >> `PROD_SHIFT;
    end else begin
        vel_wide = (vel_base * `STEP_VEL_K) >> `PROD_SHIFT;
    end
    // compared before cutting to 32 bits, so large products still clamp
    if (vel_wide > {32'h0, VEL_MAX}) begin
        next_vel = VEL_MAX;
    end else begin
        next_vel = vel_wide[31:0];
    end
end

// ----------------------------------------------------------------
// acceleration conversion
// ----------------------------------------------------------------
reg [63:0] acc_base;
reg [63:0] acc_wide;
reg [31:0] next_acc;

always @* begin
    acc_base = rate_word * per_rev;
    if (servo) begin
        acc_wide = (acc_base * SERVO_ACC_K) >> `PROD_SHIFT;
    end else begin
        // steps per second squared needs no scaling
        acc_wide = acc_base;
    end
    if (acc_wide > {32'h0, ACC_MAX}) begin
        next_acc = ACC_MAX;
    end else begin
        next_acc = acc_wide[31:0];
    end
end

// ----------------------------------------------------------------
// steps and lines clamping
// ----------------------------------------------------------------
// a zero field is raised to one rather than refused, so the load
// still completes and leaves cmd_err alone
wire [15:0] raw_lines = wdata[`SL_LINES_MSB:`SL_LINES_LSB];
wire [15:0] raw_steps = wdata[`SL_STEPS_MSB:`SL_STEPS_LSB];
reg [15:0] next_lines;
reg [15:0] next_steps;

always @* begin
    if (raw_lines < `LINES_MIN) begin
        next_lines = `LINES_MIN;
    end else if (raw_lines > `LINES_MAX) begin
        next_lines = `LINES_MAX;
    end else begin
        next_lines = raw_lines;
    end
    if (raw_steps < `STEPS_MIN) begin
        next_steps = `STEPS_MIN;
    end else if (raw_steps > `STEPS_MAX) begin
        next_steps = `STEPS_MAX;
    end else begin
        next_steps = raw_steps;
    end
end

// ----------------------------------------------------------------
// global registers
// ----------------------------------------------------------------
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        cfg <= 3'h0;
        axis_sel <= {AXW{1'b0}};
    end else begin
        if (wr_cfg) begin
            cfg <= wdata[2:0];
        end
        if (wr_sel) begin
            axis_sel <= wdata[AXW-1:0];
        end
    end
end

// set wins over the write-one clear
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        cmd_err <= 1'b0;
    end else if (wr_sl && open_stepper) begin
        cmd_err <= 1'b1;
    end else if (wr_sts && wdata[`STS_CMD_ERR]) begin
        cmd_err <= 1'b0;
    end
end

// ----------------------------------------------------------------
// per-axis storage
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < NUM_AXES; g = g + 1) begin : axis
        localparam [AXW-1:0] AXIS_ID = g;
        wire hit = (axis_sel == AXIS_ID);
        wire go = wr_start && wdata[g];

        // rates: converted at write time from the held steps or lines
        always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                vel_out[g*32 +: 32] <= 32'h0;
                acc_out[g*32 +: 32] <= 32'h0;
            end else begin
                if (hit && wr_vel) begin
                    vel_out[g*32 +: 32] <= next_vel;
                end
                if (hit && wr_acc) begin
                    acc_out[g*32 +: 32] <= next_acc;
                end
            end
        end

        // steps and lines: an open-loop stepper keeps the old pair
        always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                steps_out[g*16 +: 16] <= `STEPS_RESET;
                lines_out[g*16 +: 16] <= `LINES_RESET;
            end else if (hit && wr_sl && !open_stepper) begin
                steps_out[g*16 +: 16] <= next_steps;
                lines_out[g*16 +: 16] <= next_lines;
            end
        end

        // pending target: a later load simply replaces an unstarted one
        always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                pend_target[g*32 +: 32] <= 32'h0;
                pend_valid[g] <= 1'b0;
                pend_rel[g] <= 1'b0;
            end else if (hit && wr_tgt) begin
                pend_target[g*32 +: 32] <= wdata;
                pend_rel[g] <= relative;
                pend_valid[g] <= 1'b1;
            end else if (go) begin
                pend_valid[g] <= 1'b0;
            end
        end

        // start: the pending value is kept, so a second start repeats it
        always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                dest_out[g*32 +: 32] <= 32'h0;
                start_pulse[g] <= 1'b0;
            end else begin
                start_pulse[g] <= go;
                if (go && pend_rel[g]) begin
                    // wraps at 32 bits, like the position itself
                    dest_out[g*32 +: 32] <=
                        stop_pos[g*32 +: 32] + pend_target[g*32 +: 32];
                end else if (go) begin
                    dest_out[g*32 +: 32] <= pend_target[g*32 +: 32];
                end
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// selected-axis views for the read port
// ----------------------------------------------------------------
// every readable parameter follows axis_sel, so one index serves all
wire [31:0] sel_vel = vel_out[axis_sel*32 +: 32];
wire [31:0] sel_acc = acc_out[axis_sel*32 +: 32];
wire [31:0] sel_pend = pend_target[axis_sel*32 +: 32];
wire [31:0] sel_dest = dest_out[axis_sel*32 +: 32];

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
reg [31:0] next_rdata;

always @* begin
    next_rdata = 32'h0;
    case (addr)
        `REG_CFG: begin
            next_rdata = {29'h0, cfg};
        end
        `REG_AXIS_SEL: begin
            next_rdata = {{(32-AXW){1'b0}}, axis_sel};
        end
        `REG_VEL: begin
            next_rdata = sel_vel;
        end
        `REG_ACC: begin
            next_rdata = sel_acc;
        end
        `REG_STEPS_LINES: begin
            next_rdata = {sel_lines, sel_steps};
        end
        `REG_TARGET: begin
            next_rdata = sel_pend;
        end
        `REG_STATUS: begin
            next_rdata[`STS_CMD_ERR] = cmd_err;
            next_rdata[`STS_PEND_LSB +: NUM_AXES] = pend_valid;
        end
        `REG_DEST: begin
            next_rdata = sel_dest;
        end
        default: begin
            next_rdata = 32'h0;
        end
    endcase
end

// zero outside the answer cycle, so a stale word is never mistaken
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        rdata <= 32'h0;
    end else if (rd) begin
        rdata <= next_rdata;
    end else begin
        rdata <= 32'h0;
    end
end

endmodule

// ==== src/axis_param_defines.vh ====
// constants for the per-axis motion parameter loader
`ifndef AXIS_PARAM_DEFINES_VH
`define AXIS_PARAM_DEFINES_VH

// register byte offsets
`define REG_CFG 8'h00
`define REG_AXIS_SEL 8'h04
`define REG_VEL 8'h08
`define REG_ACC 8'h0c
`define REG_STEPS_LINES 8'h10
`define REG_TARGET 8'h14
`define REG_START 8'h18
`define REG_STATUS 8'h1c
`define REG_DEST 8'h20

// configuration bits
`define CFG_SERVO 0
`define CFG_CLOSED 1
`define CFG_RELATIVE 2

// status bits
`define STS_CMD_ERR 0
`define STS_PEND_LSB 8

// steps-and-lines word layout
`define SL_LINES_MSB 31
`define SL_LINES_LSB 16
`define SL_STEPS_MSB 15
`define SL_STEPS_LSB 0

// field limits and reset values
`define LINES_MIN 16'h0001
`define LINES_MAX 16'h3fff
`define STEPS_MIN 16'h0001
`define STEPS_MAX 16'h7fff
`define LINES_RESET 16'h00c8
`define STEPS_RESET 16'h00c8

// conversion scaling
`define US_PER_MIN 64'h0000_0000_0393_8700
`define US2_PER_S2 64'h0000_00e8_d4a5_1000
`define STEP_VEL_K 64'h0000_0000_0444_4445
`define FRAC_SHIFT 48
`define PROD_SHIFT 32
`define COUNTS_PER_LINE 64'h4

`endif
